// file: src/eag_pkg.sv
// Package of the effective address generator: types, fields, constants.
// Assumes a single core clock domain shared by every file of the block.
package eag_pkg;

    localparam int NGPR = 15;

    // Status register fields; reserved bits always read as zero.
    localparam int SR_T1 = 15;
    localparam int SR_T0 = 14;
    localparam int SR_S = 13;
    localparam int SR_M = 12;
    localparam int SR_IPM_LO = 8;
    localparam int SR_X = 4;
    localparam int SR_N = 3;
    localparam int SR_Z = 2;
    localparam int SR_V = 1;
    localparam int SR_C = 0;
    localparam logic [15:0] SR_MASK = 16'hf71f;

    // Values after reset.
    localparam logic [15:0] SR_RESET = 16'h2700;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] VBR_RESET = 32'h0000_0000;

    // Register bus byte offsets; 0x00..0x3c is the general register view.
    localparam logic [7:0] OFF_SR = 8'h40;
    localparam logic [7:0] OFF_PC = 8'h44;
    localparam logic [7:0] OFF_USP = 8'h48;
    localparam logic [7:0] OFF_ISP = 8'h4c;
    localparam logic [7:0] OFF_MSP = 8'h50;
    localparam logic [7:0] OFF_VBR = 8'h54;
    localparam logic [7:0] OFF_SFC = 8'h58;
    localparam logic [7:0] OFF_DFC = 8'h5c;
    localparam logic [7:0] OFF_CACR = 8'h60;
    localparam logic [7:0] OFF_CAAR = 8'h64;
    localparam logic [7:0] OFF_EA = 8'h68;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PTR = 2'b01
    } eag_st_e;

    typedef enum logic [3:0] {
        M_DREG = 4'b0000,
        M_AREG = 4'b0001,
        M_IND = 4'b0010,
        M_POSTINC = 4'b0011,
        M_PREDEC = 4'b0100,
        M_DISP = 4'b0101,
        M_IDX = 4'b0110,
        M_MIPOST = 4'b0111,
        M_MIPRE = 4'b1000,
        M_PCDISP = 4'b1001,
        M_PCIDX = 4'b1010,
        M_PCMIPOST = 4'b1011,
        M_PCMIPRE = 4'b1100,
        M_ABSW = 4'b1101,
        M_ABSL = 4'b1110,
        M_IMM = 4'b1111
    } eag_mode_e;

    typedef enum logic [2:0] {
        SZ_BYTE = 3'b000,
        SZ_WORD = 3'b001,
        SZ_LONG = 3'b010,
        SZ_QUAD = 3'b011,
        SZ_BITF = 3'b100
    } eag_size_e;

    typedef enum logic [1:0] {
        DS_NONE = 2'b00,
        DS_BYTE = 2'b01,
        DS_WORD = 2'b10,
        DS_LONG = 2'b11
    } eag_dsz_e;

    typedef struct packed {
        eag_mode_e mode;
        logic [2:0] an;
        logic [3:0] xn;
        logic x_long;
        logic [1:0] scale;
        logic full;
        logic [31:0] bd;
        eag_dsz_e bd_sz;
        logic [31:0] od;
        eag_dsz_e od_sz;
        eag_size_e opsz;
        logic [31:0] ext;
    } eag_req_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic is_reg;
        logic is_imm;
    } eag_res_s;

    typedef struct packed {
        eag_st_e st;
        logic [NGPR-1:0][31:0] gpr;
        logic [31:0] usp;
        logic [31:0] isp;
        logic [31:0] msp;
        logic [31:0] pc;
        logic [31:0] vbr;
        logic [31:0] cacr;
        logic [31:0] caar;
        logic [15:0] sr;
        logic [2:0] sfc;
        logic [2:0] dfc;
        eag_req_s pend;
        logic [31:0] pend_x;
        logic [31:0] ptr_addr;
        logic res_valid;
        eag_res_s res;
        logic [31:0] rd_q;
        logic [31:0] bf_q;
        logic [31:0] prdata;
    } eag_state_s;

    // Sign-extends a displacement of the given size; none gives zero.
    function automatic logic [31:0] eag_sext(logic [31:0] v, eag_dsz_e sz);
        case (sz)
            DS_BYTE: eag_sext = {{24{v[7]}}, v[7:0]};
            DS_WORD: eag_sext = {{16{v[15]}}, v[15:0]};
            DS_LONG: eag_sext = v;
            default: eag_sext = 32'h0;
        endcase
    endfunction

endpackage

// file: src/eag_addr_calc.sv
// Address adder: base plus sign-extended displacement plus scaled index.
// Assumes purely combinational use from the generator on the core clock.
`timescale 1ns/1ps
`default_nettype none
module eag_addr_calc (
    // Operands.
    input wire logic [31:0] base,
    input wire logic [31:0] disp,
    input wire eag_pkg::eag_dsz_e disp_sz,
    input wire logic [31:0] idx,
    input wire logic idx_long,
    input wire logic [1:0] scale,
    input wire logic idx_en,
    // Result.
    output logic [31:0] sum
);
    import eag_pkg::*;

    logic [31:0] x_ext;
    logic [31:0] x_scaled;

    always_comb begin
        x_ext = idx_long ? idx : eag_sext(idx, DS_WORD);
        x_scaled = idx_en ? (x_ext << scale) : 32'h0;
        sum = base + eag_sext(disp, disp_sz) + x_scaled;
    end
endmodule
`default_nettype wire

// file: src/eag_core.sv
// Effective address generator with the programmer-visible register set.
// Assumes decoder, executor and pointer fetch all run on pclk.
`timescale 1ns/1ps
`default_nettype none
module eag_core (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Register bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Address request from the decoder.
    input wire logic req_valid,
    input wire eag_pkg::eag_req_s req,
    output logic req_ready,
    // Address result.
    output logic res_valid,
    output eag_pkg::eag_res_s res,
    // Pointer fetch through the bus controller.
    output logic ptr_req,
    output logic [31:0] ptr_addr,
    input wire logic ptr_ack,
    input wire logic [31:0] ptr_data,
    // Register access from the execution unit.
    input wire logic [3:0] rd_idx,
    output logic [31:0] rd_q,
    output logic [31:0] bf_q,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire eag_pkg::eag_size_e wr_size,
    input wire logic [63:0] wr_data,
    input wire logic [4:0] bf_off,
    input wire logic [4:0] bf_wid,
    // Program counter and status.
    input wire logic pc_we,
    input wire logic [31:0] pc_wdata,
    input wire logic sr_we,
    input wire logic [15:0] sr_wdata,
    output logic [31:0] pc_q,
    output logic [15:0] sr_q
);
    import eag_pkg::*;

    eag_state_s r;
    eag_state_s n;
    logic acc;
    logic apb_wr;
    logic is_pc;
    logic [31:0] a_base;
    logic [31:0] x_val;
    logic [31:0] stp;
    logic [31:0] s1_sum;
    logic [31:0] s2_sum;
    eag_dsz_e s1_dsz;
    logic s1_xen;
    logic s2_xen;

    ////////////////////////////////////////////////////////////////////////
    // Register view: index 15 is the stack pointer chosen by S and M.
    function automatic logic [31:0] reg_view(eag_state_s s, logic [3:0] i);
        if (i != 4'hf) begin
            reg_view = s.gpr[i];
        end else if (!s.sr[SR_S]) begin
            reg_view = s.usp;
        end else if (s.sr[SR_M]) begin
            reg_view = s.msp;
        end else begin
            reg_view = s.isp;
        end
    endfunction

    function automatic eag_state_s put_reg(eag_state_s s, logic [3:0] i,
                                           logic [31:0] v);
        put_reg = s;
        if (i != 4'hf) begin
            put_reg.gpr[i] = v;
        end else if (!s.sr[SR_S]) begin
            put_reg.usp = v;
        end else if (s.sr[SR_M]) begin
            put_reg.msp = v;
        end else begin
            put_reg.isp = v;
        end
    endfunction

    function automatic logic is_mi(eag_mode_e m);
        is_mi = (m == M_MIPOST) || (m == M_MIPRE) ||
                (m == M_PCMIPOST) || (m == M_PCMIPRE);
    endfunction

    // Byte accesses through the stack pointer keep it word aligned.
    function automatic logic [31:0] step(eag_size_e z, logic [2:0] an);
        case (z)
            SZ_BYTE: step = (an == 3'h7) ? 32'h2 : 32'h1;
            SZ_WORD: step = 32'h2;
            default: step = 32'h4;
        endcase
    endfunction

    function automatic logic [31:0] bf_mask(logic [4:0] w);
        bf_mask = (w == 5'h0) ? 32'hffff_ffff : ((32'h1 << w) - 32'h1);
    endfunction

    function automatic logic apb_hit(logic [31:0] a);
        apb_hit = (a[31:8] == 24'h0) && (a[1:0] == 2'b00) &&
                  (a[7:0] <= OFF_EA);
    endfunction

    function automatic logic [31:0] apb_rd(eag_state_s s, logic [31:0] a);
        apb_rd = 32'h0;
        if (a[7:6] == 2'b00) begin
            apb_rd = reg_view(s, a[5:2]);
        end else begin
            case (a[7:0])
                OFF_SR: apb_rd = {16'h0, s.sr};
                OFF_PC: apb_rd = s.pc;
                OFF_USP: apb_rd = s.usp;
                OFF_ISP: apb_rd = s.isp;
                OFF_MSP: apb_rd = s.msp;
                OFF_VBR: apb_rd = s.vbr;
                OFF_SFC: apb_rd = {29'h0, s.sfc};
                OFF_DFC: apb_rd = {29'h0, s.dfc};
                OFF_CACR: apb_rd = s.cacr;
                OFF_CAAR: apb_rd = s.caar;
                OFF_EA: apb_rd = s.res.addr;
                default: apb_rd = 32'h0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Operand selection for the two address adders.
    always_comb begin
        acc = req_valid && (r.st == ST_IDLE);
        apb_wr = psel && penable && pwrite && apb_hit(paddr);
        is_pc = (req.mode >= M_PCDISP) && (req.mode <= M_PCMIPRE);
        a_base = is_pc ? r.pc : reg_view(r, {1'b1, req.an});
        x_val = reg_view(r, req.xn);
        stp = step(req.opsz, req.an);
        case (req.mode)
            M_DISP, M_PCDISP: s1_dsz = DS_WORD;
            M_IDX, M_PCIDX: s1_dsz = req.full ? req.bd_sz : DS_BYTE;
            M_MIPOST, M_MIPRE, M_PCMIPOST, M_PCMIPRE: s1_dsz = req.bd_sz;
            default: s1_dsz = DS_NONE;
        endcase
        s1_xen = (req.mode == M_IDX) || (req.mode == M_PCIDX) ||
                 (req.mode == M_MIPRE) || (req.mode == M_PCMIPRE);
        s2_xen = (r.pend.mode == M_MIPOST) ||
                 (r.pend.mode == M_PCMIPOST);
    end

    eag_addr_calc u_pre (
        .base(a_base),
        .disp(req.bd),
        .disp_sz(s1_dsz),
        .idx(x_val),
        .idx_long(req.x_long),
        .scale(req.scale),
        .idx_en(s1_xen),
        .sum(s1_sum)
    );

    eag_addr_calc u_post (
        .base(ptr_data),
        .disp(r.pend.od),
        .disp_sz(r.pend.od_sz),
        .idx(r.pend_x),
        .idx_long(r.pend.x_long),
        .scale(r.pend.scale),
        .idx_en(s2_xen),
        .sum(s2_sum)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state: address sequence, then executor, then register bus.
    always_comb begin
        n = r;
        n.res_valid = 1'b0;
        n.rd_q = reg_view(r, rd_idx);
        n.bf_q = (reg_view(r, rd_idx) >> bf_off) & bf_mask(bf_wid);
        case (r.st)
            ST_IDLE: begin
                if (req_valid) begin
                    n.pend = req;
                    n.pend_x = x_val;
                    n.res_valid = 1'b1;
                    n.res = '0;
                    n.res.addr = s1_sum;
                    case (req.mode)
                        M_DREG, M_AREG: begin
                            n.res.is_reg = 1'b1;
                            n.res.data = reg_view(r,
                                {req.mode == M_AREG, req.an});
                        end
                        M_POSTINC: begin
                            n = put_reg(n, {1'b1, req.an},
                                        a_base + stp);
                        end
                        M_PREDEC: begin
                            n.res.addr = a_base - stp;
                            n = put_reg(n, {1'b1, req.an}, a_base - stp);
                        end
                        M_ABSW: n.res.addr = eag_sext(req.ext,
                                                      DS_WORD);
                        M_ABSL: n.res.addr = req.ext;
                        M_IMM: begin
                            n.res.is_imm = 1'b1;
                            n.res.addr = 32'h0;
                            case (req.opsz)
                                SZ_BYTE: n.res.data = {24'h0, req.ext[7:0]};
                                SZ_WORD: n.res.data = {16'h0, req.ext[15:0]};
                                default: n.res.data = req.ext;
                            endcase
                        end
                        default: begin
                            if (is_mi(req.mode)) begin
                                n.res_valid = 1'b0;
                                n.ptr_addr = s1_sum;
                                n.st = ST_PTR;
                            end
                        end
                    endcase
                end
            end
            ST_PTR: begin
                if (ptr_ack) begin
                    n.res_valid = 1'b1;
                    n.res = '0;
                    n.res.addr = s2_sum;
                    n.st = ST_IDLE;
                end
            end
            default: n.st = ST_IDLE;
        endcase

        if (wr_en && !wr_idx[3]) begin
            case (wr_size)
                SZ_BYTE: n.gpr[wr_idx] = {n.gpr[wr_idx][31:8], wr_data[7:0]};
                SZ_WORD: n.gpr[wr_idx] = {n.gpr[wr_idx][31:16],
                                          wr_data[15:0]};
                SZ_QUAD: begin
                    n.gpr[wr_idx] = wr_data[31:0];
                    n.gpr[{1'b0, wr_idx[2:0] + 3'h1}] = wr_data[63:32];
                end
                SZ_BITF: begin
                    n.gpr[wr_idx] = (n.gpr[wr_idx] &
                        ~(bf_mask(bf_wid) << bf_off)) |
                        ((wr_data[31:0] & bf_mask(bf_wid)) << bf_off);
                end
                default: n.gpr[wr_idx] = wr_data[31:0];
            endcase
        end else if (wr_en && wr_size == SZ_WORD) begin
            n = put_reg(n, wr_idx, eag_sext(wr_data[31:0],
                                            DS_WORD));
        end else if (wr_en && wr_size == SZ_LONG) begin
            n = put_reg(n, wr_idx, wr_data[31:0]);
        end

        if (pc_we) begin
            n.pc = pc_wdata;
        end
        if (sr_we) begin
            n.sr = sr_wdata;
        end

        if (apb_wr && paddr[7:6] == 2'b00) begin
            n = put_reg(n, paddr[5:2], pwdata);
        end else if (apb_wr) begin
            case (paddr[7:0])
                OFF_SR: n.sr = pwdata[15:0];
                OFF_PC: n.pc = pwdata;
                OFF_USP: n.usp = pwdata;
                OFF_ISP: n.isp = pwdata;
                OFF_MSP: n.msp = pwdata;
                OFF_VBR: n.vbr = pwdata;
                OFF_SFC: n.sfc = pwdata[2:0];
                OFF_DFC: n.dfc = pwdata[2:0];
                OFF_CACR: n.cacr = pwdata;
                OFF_CAAR: n.caar = pwdata;
                default: n.caar = n.caar;
            endcase
        end
        n.sr = n.sr & SR_MASK;

        if (psel && !penable) begin
            n.prdata = apb_rd(n, paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.sr <= SR_RESET;
            r.pc <= PC_RESET;
            r.vbr <= VBR_RESET;
        end else begin
            r <= n;
        end
    end

    always_comb begin
        pready = 1'b1;
        prdata = r.prdata;
        pslverr = psel && penable && !apb_hit(paddr);
        req_ready = (r.st == ST_IDLE);
        res_valid = r.res_valid;
        res = r.res;
        ptr_req = (r.st == ST_PTR);
        ptr_addr = r.ptr_addr;
        rd_q = r.rd_q;
        bf_q = r.bf_q;
        pc_q = r.pc;
        sr_q = r.sr;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    logic [31:0] an_now;
    logic [31:0] d16;
    logic [31:0] od_sum;
    logic [31:0] rd_view;
    logic quiet;

    always_comb begin
        an_now = reg_view(r, {1'b1, r.pend.an});
        d16 = a_base + eag_sext(req.bd, DS_WORD);
        od_sum = ptr_data + eag_sext(r.pend.od, r.pend.od_sz);
        rd_view = reg_view(r, rd_idx);
        quiet = !wr_en && !apb_wr;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_SR_RSV: assert property ((sr_q & ~SR_MASK) == 16'h0)
        else $error("reserved status bits set");
    AST_POSTINC: assert property (
        acc && req.mode == M_POSTINC && quiet |=>
        res_valid && res.addr == $past(a_base) &&
        an_now == $past(a_base) + $past(stp))
        else $error("postincrement wrong");
    AST_PREDEC: assert property (
        acc && req.mode == M_PREDEC && quiet |=>
        res_valid && an_now == res.addr &&
        res.addr == $past(a_base) - $past(stp))
        else $error("predecrement wrong");
    AST_ABSW: assert property (
        acc && req.mode == M_ABSW |=>
        res_valid && res.addr[31:16] == {16{res.addr[15]}})
        else $error("short absolute not extended");
    AST_DISP16: assert property (
        acc && req.mode == M_DISP |=> res.addr == $past(d16))
        else $error("displacement sum wrong");
    AST_MI_ISSUE: assert property (
        acc && is_mi(req.mode) |=> ptr_req && !res_valid && !req_ready)
        else $error("pointer fetch not issued");
    AST_OD_AFTER: assert property (
        ptr_req && ptr_ack && r.pend.mode == M_MIPRE |=>
        res_valid && res.addr == $past(od_sum) ##1 !res_valid)
        else $error("outer displacement wrong");
    AST_AREG_BYTE: assert property (
        wr_en && wr_idx[3] && wr_size == SZ_BYTE && !acc && !apb_wr
        |=> $stable(r.gpr) && $stable(r.usp) && $stable(r.isp))
        else $error("byte write changed address reg");
    AST_RDQ: assert property (
        1'b1 |=> rd_q == $past(rd_view))
        else $error("read port mismatch");

    COV_MIPRE: cover property (acc && req.mode == M_MIPRE ##[1:20] res_valid);
    COV_POSTINC: cover property (acc && req.mode == M_POSTINC);
    COV_QUAD: cover property (wr_en && wr_size == SZ_QUAD);
endmodule
`default_nettype wire

// file: verif/eag_ptr_mem.sv
// Pointer fetch responder standing in for the core bus controller.
// Assumes pclk and presetn of the generator; dly sets the answer wait.
`timescale 1ns/1ps
`default_nettype none
module eag_ptr_mem (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Fetch handshake.
    input wire logic ptr_req,
    input wire logic [31:0] ptr_addr,
    input wire logic [1:0] dly,
    output logic ptr_ack,
    output logic [31:0] ptr_data
);
    logic [1:0] cnt;
    // Outside an answer the data lines show the inverse of the last word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_ack <= 1'b0;
            ptr_data <= 32'h0;
            cnt <= 2'h0;
        end else if (ptr_ack) begin
            ptr_ack <= 1'b0;
            ptr_data <= ~ptr_data;
            cnt <= 2'h0;
        end else if (ptr_req && cnt == dly) begin
            ptr_ack <= 1'b1;
            ptr_data <= {ptr_addr[15:0], ptr_addr[31:16]} ^ 32'hc3c3_3c3c;
        end else if (ptr_req) begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule
`default_nettype wire

// file: verif/tb.sv
// Random address requests against a register model kept by the bench.
// Assumes the pointer responder answers every fetch within four cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import eag_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, req_valid = 1'b0, wr_en = 1'b0, pc_we = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, pc_wdata = 32'h0;
    logic [63:0] wr_data = 64'h0;
    logic [3:0] wr_idx = 4'h0;
    logic [1:0] dly = 2'h0;
    eag_size_e wr_size = SZ_BYTE;
    eag_req_s req = '0, rq = '0;
    logic [3:0] rd_idx = 4'h0;
    logic [4:0] bf_off = 5'h0, bf_wid = 5'h0;
    eag_res_s res;
    logic pready, pslverr, req_ready, res_valid, ptr_req, ptr_ack, err;
    logic [31:0] prdata, ptr_addr, ptr_data, rd_q, bf_q, pc_q, q, pcm, e;
    logic [15:0] sr_q;
    logic [31:0] gm [0:14];
    int n_mismatch = 0, n_compared = 0, cyc = 0;

    eag_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .req_valid, .req, .req_ready,
        .res_valid, .res, .ptr_req, .ptr_addr, .ptr_ack, .ptr_data,
        .rd_idx, .rd_q, .bf_q, .wr_en, .wr_idx, .wr_size, .wr_data,
        .bf_off, .bf_wid, .pc_we, .pc_wdata, .sr_we(1'b0),
        .sr_wdata(16'h0), .pc_q, .sr_q);
    eag_ptr_mem u_mem (.pclk, .presetn, .ptr_req, .ptr_addr, .dly,
        .ptr_ack, .ptr_data);

    always #5 pclk = ~pclk;

    task automatic stop_test();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        n_compared++;
        if (got !== ex) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(logic [3:0] i, eag_size_e s, logic [63:0] d);
        @(posedge pclk);
        wr_en <= 1'b1;
        wr_idx <= i;
        wr_size <= s;
        wr_data <= d;
        @(posedge pclk);
        wr_en <= 1'b0;
    endtask

    function automatic logic [31:0] sx(logic [31:0] v, eag_dsz_e z);
        case (z)
            DS_BYTE: return {{24{v[7]}}, v[7:0]};
            DS_WORD: return {{16{v[15]}}, v[15:0]};
            DS_LONG: return v;
            default: return 32'h0;
        endcase
    endfunction

    function automatic logic [31:0] mem(logic [31:0] a);
        return {a[15:0], a[31:16]} ^ 32'hc3c3_3c3c;
    endfunction

    task automatic ea();
        logic [31:0] b, xi, bd, od, st, ex, dv;
        int k;
        @(posedge pclk);
        req <= rq;
        req_valid <= 1'b1;
        @(posedge pclk);
        req_valid <= 1'b0;
        b = (req.mode inside {[M_PCDISP:M_PCMIPRE]}) ? pcm : gm[8 + req.an];
        xi = req.x_long ? gm[req.xn] : sx(gm[req.xn], DS_WORD);
        xi = xi << req.scale;
        bd = sx(req.bd, req.bd_sz);
        od = sx(req.od, req.od_sz);
        st = 32'h1 << req.opsz;
        dv = 32'h0;
        ex = 32'h0;
        case (req.mode)
            M_DREG: dv = gm[req.an];
            M_AREG: dv = gm[8 + req.an];
            M_IND, M_POSTINC: ex = b;
            M_PREDEC: ex = b - st;
            M_DISP, M_PCDISP: ex = b + sx(req.bd, DS_WORD);
            M_IDX, M_PCIDX: ex = b + xi + (req.full ? bd : sx(req.bd, DS_BYTE));
            M_MIPOST, M_PCMIPOST: ex = mem(b + bd) + xi + od;
            M_MIPRE, M_PCMIPRE: ex = mem(b + bd + xi) + od;
            M_ABSW: ex = sx(req.ext, DS_WORD);
            M_ABSL: ex = req.ext;
            default: dv = req.ext & ((32'h1 << (8 << req.opsz)) - 32'h1);
        endcase
        if (req.mode inside {M_POSTINC, M_PREDEC})
            gm[8 + req.an] = (req.mode == M_POSTINC) ? b + st : b - st;
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (res_valid !== 1'b1 && k < 40);
        if (!(req.mode inside {M_MIPOST, M_MIPRE, M_PCMIPOST, M_PCMIPRE}))
            chk("latency", 32'h1, 32'(k));
        chk("kind", {30'h0, req.mode inside {M_DREG, M_AREG},
            req.mode == M_IMM}, {30'h0, res.is_reg, res.is_imm});
        if (req.mode inside {M_DREG, M_AREG, M_IMM})
            chk("res.data", dv, res.data);
        else
            chk("res.addr", ex, res.addr);
    endtask

    initial begin
        void'($urandom(7));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, {24'h0, OFF_SR}, 32'h0);
        chk("sr", 32'h2700, q);
        chk("sr_q", 32'h2700, {16'h0, sr_q});
        for (int i = 0; i < 15; i++) begin
            gm[i] = $urandom();
            apb(1'b1, 32'(i * 4), gm[i]);
        end
        pcm = $urandom();
        pc_we <= 1'b1;
        pc_wdata <= pcm;
        @(posedge pclk);
        pc_we <= 1'b0;
        apb(1'b0, {24'h0, OFF_PC}, 32'h0);
        chk("pc", pcm, q);
        chk("pc_q", pcm, pc_q);
        apb(1'b1, 32'h6c, pcm);
        chk("unmapped", 32'h1, {31'h0, err});
        e = $urandom();
        wr(4'd2, SZ_QUAD, {e, ~e});
        gm[2] = ~e;
        gm[3] = e;
        wr(4'd4, SZ_BYTE, {32'h0, e});
        gm[4][7:0] = e[7:0];
        wr(4'd9, SZ_WORD, {32'h0, e});
        gm[9] = sx(e, DS_WORD);
        wr(4'd10, SZ_BYTE, {32'h0, e});
        bf_off <= 5'd4;
        bf_wid <= 5'd8;
        wr(4'd5, SZ_BITF, {32'h0, e});
        gm[5][11:4] = e[7:0];
        rd_idx <= 4'd5;
        repeat (2) @(posedge pclk);
        chk("rd_q", gm[5], rd_q);
        chk("bf_q", {24'h0, e[7:0]}, bf_q);
        for (int i = 0; i < 300; i++) begin
            rq.mode = eag_mode_e'(4'($urandom()));
            rq.an = 3'($urandom_range(0, 6));
            rq.xn = 4'($urandom_range(0, 14));
            {rq.x_long, rq.scale, rq.full} = 4'($urandom());
            rq.bd = (i == 1) ? 32'h0000_fff0 : $urandom();
            rq.bd_sz = eag_dsz_e'(2'($urandom()));
            rq.od = $urandom();
            rq.od_sz = $urandom_range(0, 1) ? DS_WORD : DS_LONG;
            rq.opsz = eag_size_e'(3'($urandom_range(0, 2)));
            rq.ext = (i == 0) ? 32'h0001_8000 : $urandom();
            if (i < 2)
                rq.mode = (i == 0) ? M_ABSW : M_DISP;
            dly = 2'($urandom());
            ea();
        end
        for (int i = 0; i < 15; i++) begin
            apb(1'b0, 32'(i * 4), 32'h0);
            chk("gpr", gm[i], q);
        end
        stop_test();
    end
endmodule
`default_nettype wire
